// *** hdl/panel_lock_pkg.sv ***
// package for the panel key lock and beeper control block
// assumes a 50 MHz system clock and a single top module using it
package panel_lock_pkg;
  // clock and hold timing
  localparam int CLOCK_HZ = 50000000;
  localparam int UNLOCK_HOLD_MS = 1000;
  localparam int UNLOCK_HOLD_CYCLES = (CLOCK_HZ / 1000) * UNLOCK_HOLD_MS;
  // key vector field positions
  localparam int KEY_W = 16;
  localparam int KEY_REF_PCT = 0;
  localparam int KEY_ABS = 1;
  localparam int KEY_UNIT = 2;
  localparam int KEY_NUM_LO = 3;
  localparam int KEY_NUM_HI = 12;
  localparam int KEY_SOFT = 13;
  localparam int KEY_LOCAL = 14;
  localparam int KEY_OTHER = 15;
  // mask of keys still live in the settings-lock level
  localparam logic [15:0] COMP_KEY_MASK = 16'h1fff;
  localparam logic [15:0] SOFT_KEY_MASK = 16'h2000;
  // reset values of the beeper settings
  localparam logic KEY_BEEP_RST = 1'b1;
  localparam logic JUDGE_BEEP_RST = 1'b0;
  localparam logic [2:0] JUDGE_SEL_RST = 3'h7;
  // judgment outcome bit positions: hi, in, lo
  localparam int JUDGE_HI = 2;
  localparam int JUDGE_IN = 1;
  localparam int JUDGE_LO = 0;

  // key lock levels, gray coded
  typedef enum logic [1:0] {
    LOCK_OFF = 2'b00,
    LOCK_SETTINGS = 2'b01,
    LOCK_FULL = 2'b11
  } lock_level_t;

  // indicator group
  typedef struct packed {
    logic settings_lock;
    logic full_lock;
    logic unlock_label;
  } lock_ind_t;
endpackage

// *** hdl/panel_key_lock.sv ***
// panel key lock level, external lock override, unlock hold timer and beeper enables
// assumes key and lock inputs arrive from pins asynchronous to clock
`timescale 1ns/1ns
`default_nettype none
module panel_key_lock #(
  parameter int HOLD_CYCLES = panel_lock_pkg::UNLOCK_HOLD_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // panel keys and external connector
  input wire logic [panel_lock_pkg::KEY_W-1:0] keys_raw,
  input wire logic ext_lock_n_raw,
  // settings screen requests
  input wire logic level_wr,
  input wire logic [1:0] level_in,
  input wire logic meas_screen,
  input wire logic key_beep_wr,
  input wire logic key_beep_in,
  input wire logic judge_beep_wr,
  input wire logic judge_beep_in,
  input wire logic judge_sel_wr,
  input wire logic [2:0] judge_sel_in,
  input wire logic factory_reset,
  // judgment strobe from the comparator
  input wire logic judge_valid,
  input wire logic [2:0] judge_result,
  // outputs to settings and remote logic
  output logic [panel_lock_pkg::KEY_W-1:0] keys_out,
  output var panel_lock_pkg::lock_ind_t ind,
  output logic [1:0] lock_level,
  output logic unlock_pulse,
  output logic key_beep_en,
  output logic judge_beep_en,
  output logic [2:0] judge_sel,
  output logic key_beep,
  output logic judge_beep
);
  import panel_lock_pkg::*;

  // ----------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------
  logic rst_s1_r, rst_sync_n;
  logic [KEY_W-1:0] key_s1_r, key_s2_r, key_prev_r;
  logic ext_s1_r, ext_s2_r;

  // reset released through two flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_sync_n <= rst_s1_r;
    end
  end

  // two-flop synchronisers, external lock idles high
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      key_s1_r <= 16'h0000;
      key_s2_r <= 16'h0000;
      key_prev_r <= 16'h0000;
      ext_s1_r <= 1'b1;
      ext_s2_r <= 1'b1;
    end else begin
      key_s1_r <= keys_raw;
      key_s2_r <= key_s1_r;
      key_prev_r <= key_s2_r;
      ext_s1_r <= ext_lock_n_raw;
      ext_s2_r <= ext_s1_r;
    end
  end

  // ----------------------------------------
  // lock level and key gating
  // ----------------------------------------
  lock_level_t level_r, level_nxt;
  logic [KEY_W-1:0] key_press, level_mask, pass_mask;
  logic ext_locked, panel_locked, soft_held;
  logic [31:0] hold_cnt_r;
  logic fired_r, hold_done;

  // decoded lock state, new presses and a usable unlock key
  assign ext_locked = !ext_s2_r;
  assign panel_locked = (level_r != LOCK_OFF);
  assign key_press = key_s2_r & ~key_prev_r;
  assign soft_held = key_s2_r[KEY_SOFT] && !ext_locked;

  // keys allowed per level
  function automatic logic [KEY_W-1:0] mask_of(input lock_level_t lv);
    case (lv)
      LOCK_OFF: mask_of = 16'hffff;
      LOCK_SETTINGS: mask_of = COMP_KEY_MASK | SOFT_KEY_MASK;
      LOCK_FULL: mask_of = SOFT_KEY_MASK;
      default: mask_of = SOFT_KEY_MASK;
    endcase
  endfunction

  assign level_mask = mask_of(level_r);
  assign pass_mask = ext_locked ? 16'h0000 : level_mask;
  assign hold_done = panel_locked && soft_held && !fired_r
                     && (hold_cnt_r == HOLD_CYCLES - 1);

  // level select; screen writes only while no panel lock is set and keys are not externally blocked
  always_comb begin
    level_nxt = level_r;
    if (factory_reset) begin
      level_nxt = LOCK_OFF;
    end else if (hold_done) begin
      level_nxt = LOCK_OFF;
    end else if (level_wr && !ext_locked && !panel_locked) begin
      case (level_in)
        2'h0: level_nxt = LOCK_OFF;
        2'h1: level_nxt = LOCK_SETTINGS;
        2'h2: level_nxt = LOCK_FULL;
        default: level_nxt = level_r;
      endcase
    end
  end

  // level register and one-shot hold timer
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      level_r <= LOCK_OFF;
      hold_cnt_r <= 32'h0000_0000;
      fired_r <= 1'b0;
    end else begin
      level_r <= level_nxt;
      // count only while the key is held on a panel lock
      if (!soft_held || !panel_locked) begin
        hold_cnt_r <= 32'h0000_0000;
      end else if (!fired_r && !hold_done) begin
        hold_cnt_r <= hold_cnt_r + 32'h0000_0001;
      end
      // re-armed only by letting go or by the external lock, so relocking mid-press cannot fire again
      if (!soft_held) begin
        fired_r <= 1'b0;
      end else if (hold_done) begin
        fired_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // beeper settings
  // ----------------------------------------
  logic key_beep_r, judge_beep_r;
  logic [2:0] judge_sel_r;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      key_beep_r <= KEY_BEEP_RST;
      judge_beep_r <= JUDGE_BEEP_RST;
      judge_sel_r <= JUDGE_SEL_RST;
    end else if (factory_reset) begin
      key_beep_r <= KEY_BEEP_RST;
      judge_beep_r <= JUDGE_BEEP_RST;
      judge_sel_r <= JUDGE_SEL_RST;
    end else begin
      if (key_beep_wr) key_beep_r <= key_beep_in;
      if (judge_beep_wr) judge_beep_r <= judge_beep_in;
      if (judge_sel_wr) judge_sel_r <= judge_sel_in;
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  logic [KEY_W-1:0] keys_out_r;
  logic kb_r, jb_r, unl_r;
  lock_ind_t ind_r;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      keys_out_r <= 16'h0000;
      kb_r <= 1'b0;
      jb_r <= 1'b0;
      unl_r <= 1'b0;
      ind_r <= '0;
    end else begin
      keys_out_r <= key_press & pass_mask;
      kb_r <= key_beep_r && |(key_press & pass_mask);
      jb_r <= judge_valid && judge_beep_r && |(judge_result & judge_sel_r);
      unl_r <= hold_done;
      ind_r.settings_lock <= meas_screen && level_r == LOCK_SETTINGS;
      ind_r.full_lock <= meas_screen && level_r == LOCK_FULL;
      ind_r.unlock_label <= panel_locked && !ext_locked;
    end
  end

  // outputs straight from their registers
  assign keys_out = keys_out_r;
  assign ind = ind_r;
  assign lock_level = level_r;
  assign unlock_pulse = unl_r;
  assign key_beep_en = key_beep_r;
  assign judge_beep_en = judge_beep_r;
  assign judge_sel = judge_sel_r;
  assign key_beep = kb_r;
  assign judge_beep = jb_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_ext_low;
    ext_locked;
  endsequence

  AST_FULL_MASK: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (level_r == LOCK_FULL && !ext_locked) |=> ((keys_out & ~SOFT_KEY_MASK) == 16'h0000))
    else $error("full lock passed a key");
  AST_SET_MASK: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (level_r == LOCK_SETTINGS) |=> (keys_out[KEY_OTHER] == 1'b0 && keys_out[KEY_LOCAL] == 1'b0))
    else $error("settings lock passed a blocked key");
  AST_EXT_BLOCK: assert property (@(posedge clock) disable iff (!rst_sync_n)
    s_ext_low |=> (keys_out == 16'h0000))
    else $error("key passed under external lock");
  AST_EXT_NO_UNLOCK: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (s_ext_low and panel_locked) |=> (level_r == $past(level_r) || factory_reset == 1'b1
      || $past(factory_reset)))
    else $error("lock changed under external lock");
  AST_IND_SET: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (meas_screen && level_r == LOCK_SETTINGS) |=> ind.settings_lock)
    else $error("settings indicator missing");
  AST_IND_FULL: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (meas_screen && level_r == LOCK_FULL) |=> ind.full_lock)
    else $error("full indicator missing");
  AST_LABEL: assert property (@(posedge clock) disable iff (!rst_sync_n)
    s_ext_low |=> !ind.unlock_label)
    else $error("unlock label shown for external lock");
  AST_HOLD_TIME: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (level_r != LOCK_OFF && $past(level_r) != LOCK_OFF && level_nxt == LOCK_OFF
      && !factory_reset) |-> (hold_cnt_r == HOLD_CYCLES - 1 && soft_held))
    else $error("unlock without full hold");
  AST_ONE_SHOT: assert property (@(posedge clock) disable iff (!rst_sync_n)
    unlock_pulse |-> !$past(unlock_pulse))
    else $error("hold timer fired twice");
  AST_JUDGE: assert property (@(posedge clock) disable iff (!rst_sync_n)
    judge_beep |-> ($past(judge_beep_r) && $past(judge_valid)
      && |($past(judge_result) & $past(judge_sel_r))))
    else $error("judgment beep without cause");
  AST_BEEP_RST: assert property (@(posedge clock) disable iff (!rst_sync_n)
    factory_reset |=> (key_beep_en && !judge_beep_en))
    else $error("beeper defaults wrong");

  // level writes and refusals
  AST_LEVEL_SET: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (level_wr && level_in == 2'h1 && !factory_reset && !ext_locked && !panel_locked)
      |=> (level_r == LOCK_SETTINGS))
    else $error("settings lock write lost");
  AST_LEVEL_FULL: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (level_wr && level_in == 2'h2 && !factory_reset && !ext_locked && !panel_locked)
      |=> (level_r == LOCK_FULL))
    else $error("full lock write lost");
  AST_LEVEL_HELD: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (panel_locked && !hold_done && !factory_reset) |=> (level_r == $past(level_r)))
    else $error("panel lock left without a full hold");

  // keys that must still pass
  AST_SET_PASS: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (level_r == LOCK_SETTINGS && !ext_locked && key_press[KEY_ABS]) |=> keys_out[KEY_ABS])
    else $error("settings lock dropped a comparator key");
  AST_FULL_PASS: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (level_r == LOCK_FULL && !ext_locked && key_press[KEY_SOFT]) |=> keys_out[KEY_SOFT])
    else $error("full lock dropped the unlock key");
  AST_EXT_RELEASE: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (!ext_locked && level_r == LOCK_OFF && key_press[KEY_OTHER]) |=> keys_out[KEY_OTHER])
    else $error("key lost with no lock active");

  // indicators
  AST_IND_OFF: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !meas_screen |=> (!ind.settings_lock && !ind.full_lock))
    else $error("lock indicator off the measurement screen");
  AST_LABEL_ON: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (panel_locked && !ext_locked) |=> ind.unlock_label)
    else $error("unlock label missing on panel lock");

  // hold timer steps
  sequence s_unlock_fire;
    unlock_pulse;
  endsequence
  sequence s_key_still_held;
    soft_held;
  endsequence

  AST_HOLD_COUNT: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (soft_held && panel_locked && !fired_r && !hold_done)
      |=> (hold_cnt_r == $past(hold_cnt_r) + 32'h0000_0001))
    else $error("hold timer did not advance");
  AST_HOLD_RESTART: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !soft_held |=> (hold_cnt_r == 32'h0000_0000))
    else $error("hold timer kept its count after release");
  AST_FIRE_ONCE: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (s_unlock_fire ##1 s_key_still_held) |-> !hold_done)
    else $error("hold timer fired again in one press");

  // beepers
  AST_KEY_BEEP_OFF: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !key_beep_r |=> !key_beep)
    else $error("key beep while disabled");
  AST_JUDGE_OFF: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !judge_beep_r |=> !judge_beep)
    else $error("judgment beep while disabled");
  AST_JUDGE_HIT: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (judge_valid && judge_beep_r && judge_result[JUDGE_IN] && judge_sel_r[JUDGE_IN])
      |=> judge_beep)
    else $error("selected judgment gave no beep");
  AST_SEL_RST: assert property (@(posedge clock) disable iff (!rst_sync_n)
    factory_reset |=> (judge_sel == JUDGE_SEL_RST && lock_level == 2'h0))
    else $error("factory reset left outcome select or level");
endmodule
`default_nettype wire

// *** verif/panel_front_model.sv ***
// model of the front panel keys and the external lock line
// assumes the bench steers it through key_cmd and lock_cmd
`timescale 1ns/1ns
`default_nettype none
module panel_front_model (
  // clock
  input wire logic clock,
  // commands from the bench
  input wire logic [15:0] key_cmd,
  input wire logic lock_cmd,
  // pins toward the lock block
  output logic [15:0] keys_raw,
  output logic ext_lock_n_raw
);
  // pins move after the rising edge, high line ends the lock
  always_ff @(posedge clock) begin
    keys_raw <= key_cmd;
    ext_lock_n_raw <= ~lock_cmd;
  end
endmodule
`default_nettype wire

// *** verif/panel_key_lock_tb.sv ***
// self-checking bench for the panel key lock block
// assumes the hold count is shortened to 8 cycles
`timescale 1ns/1ns
`default_nettype none
module panel_key_lock_tb;
  import panel_lock_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, lock_cmd = 1'b0, meas_screen = 1'b1;
  logic level_wr = 1'b0, key_beep_wr = 1'b0, key_beep_in = 1'b0, judge_beep_wr = 1'b0;
  logic judge_beep_in = 1'b0, judge_sel_wr = 1'b0, factory_reset = 1'b0, judge_valid = 1'b0;
  logic [1:0] level_in = 2'h0;
  logic [2:0] judge_sel_in = 3'h0, judge_result = 3'h0, judge_sel;
  logic [15:0] key_cmd = 16'h0, keys_raw, keys_out, acc_k;
  logic ext_lock_n_raw, unlock_pulse, key_beep_en, judge_beep_en, key_beep, judge_beep;
  logic acc_b, acc_j;
  logic [1:0] lock_level;
  lock_ind_t ind;
  int err_total = 0, check_count = 0, pulses;
  // ---------------------------------------------
  // clock, far side and device
  // ---------------------------------------------
  initial forever #10 clock = ~clock;
  panel_front_model front (.clock(clock), .key_cmd(key_cmd), .lock_cmd(lock_cmd),
    .keys_raw(keys_raw), .ext_lock_n_raw(ext_lock_n_raw));
  panel_key_lock #(.HOLD_CYCLES(8)) DUT (.clock(clock), .rst_n(rst_n), .keys_raw(keys_raw),
    .ext_lock_n_raw(ext_lock_n_raw), .level_wr(level_wr), .level_in(level_in),
    .meas_screen(meas_screen), .key_beep_wr(key_beep_wr), .key_beep_in(key_beep_in),
    .judge_beep_wr(judge_beep_wr), .judge_beep_in(judge_beep_in),
    .judge_sel_wr(judge_sel_wr), .judge_sel_in(judge_sel_in), .factory_reset(factory_reset),
    .judge_valid(judge_valid), .judge_result(judge_result), .keys_out(keys_out), .ind(ind),
    .lock_level(lock_level), .unlock_pulse(unlock_pulse), .key_beep_en(key_beep_en),
    .judge_beep_en(judge_beep_en), .judge_sel(judge_sel), .key_beep(key_beep),
    .judge_beep(judge_beep));
  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  // compare and count
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      err_total++;
    end
  endtask
  // falling edges, gathering the one-cycle pulses
  task automatic step(input int n);
    repeat (n) begin
      @(negedge clock);
      acc_k = acc_k | keys_out;
      acc_b = acc_b | key_beep;
      acc_j = acc_j | judge_beep;
      pulses = pulses + unlock_pulse;
    end
  endtask
  task automatic clr();
    acc_k = 16'h0;
    acc_b = 1'b0;
    acc_j = 1'b0;
    pulses = 0;
  endtask
  // hold keys for n cycles, then release
  task automatic hold(input logic [15:0] k, input int n);
    clr();
    key_cmd = k;
    step(n);
    key_cmd = 16'h0;
    step(6);
  endtask
  // one-cycle setting strobe: 0 level 1 key beep 2 judge beep 3 select 4 factory 5 judgment
  task automatic wr(input int sel, input logic [2:0] v);
    clr();
    step(1);
    case (sel)
      0: begin level_wr = 1'b1; level_in = v[1:0]; end
      1: begin key_beep_wr = 1'b1; key_beep_in = v[0]; end
      2: begin judge_beep_wr = 1'b1; judge_beep_in = v[0]; end
      3: begin judge_sel_wr = 1'b1; judge_sel_in = v; end
      4: factory_reset = 1'b1;
      default: begin judge_valid = 1'b1; judge_result = v; end
    endcase
    step(1);
    {level_wr, key_beep_wr, judge_beep_wr, judge_sel_wr, factory_reset, judge_valid} = 6'h0;
    step(4);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    step(4);
    check("key_beep_en", key_beep_en, 16'h1);
    check("judge_beep_en", judge_beep_en, 16'h0);
    check("judge_sel", judge_sel, 16'h7);
    hold(16'h8000, 3);
    check("keys_out", acc_k, 16'h8000);
    check("key_beep", acc_b, 16'h1);
    wr(0, 3'h1);
    check("lock_level", lock_level, 16'h1);
    check("ind", ind, 16'h5);
    meas_screen = 1'b0;
    step(3);
    check("settings_lock", ind.settings_lock, 16'h0);
    meas_screen = 1'b1;
    hold(16'h0002, 3);
    check("keys_out", acc_k, 16'h0002);
    hold(16'h8000, 3);
    check("keys_out", acc_k, 16'h0);
    wr(0, 3'h2);
    check("lock_level", lock_level, 16'h1);
    hold(16'h2000, 4);
    hold(16'h2000, 6);
    check("lock_level", lock_level, 16'h1);
    hold(16'h2000, 20);
    check("lock_level", lock_level, 16'h0);
    check("unlock_pulse", pulses, 16'h1);
    wr(0, 3'h2);
    check("lock_level", lock_level, 16'h3);
    check("ind", ind, 16'h3);
    hold(16'h4002, 3);
    check("keys_out", acc_k, 16'h0);
    lock_cmd = 1'b1;
    step(5);
    check("ind", ind, 16'h2);
    hold(16'h2000, 20);
    check("lock_level", lock_level, 16'h3);
    lock_cmd = 1'b0;
    step(5);
    check("ind", ind, 16'h3);
    hold(16'h2000, 20);
    check("lock_level", lock_level, 16'h0);
    lock_cmd = 1'b1;
    hold(16'h8000, 3);
    check("keys_out", acc_k, 16'h0);
    lock_cmd = 1'b0;
    step(5);
    hold(16'h8000, 3);
    check("keys_out", acc_k, 16'h8000);
    wr(2, 3'h1);
    wr(3, 3'h2);
    check("judge_beep_en", judge_beep_en, 16'h1);
    wr(5, 3'h2);
    check("judge_beep", acc_j, 16'h1);
    wr(5, 3'h4);
    check("judge_beep", acc_j, 16'h0);
    wr(2, 3'h0);
    wr(5, 3'h2);
    check("judge_beep", acc_j, 16'h0);
    wr(1, 3'h0);
    hold(16'h8000, 3);
    check("key_beep", acc_b, 16'h0);
    wr(0, 3'h1);
    wr(4, 3'h0);
    check("cfg", {lock_level, key_beep_en, judge_beep_en, judge_sel}, 16'h17);
    print_verdict();
  end
endmodule
`default_nettype wire
